// ==== inc/eac_pkg.sv ====
// eeprom access control: shared offsets, fields, keys and timing
// assumes a byte-wide register port with a 9-bit address
package eac_pkg;

    // ********************************************************
    // register offsets
    // ********************************************************
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 9'h18C;
    localparam logic [ADDR_W-1:0] OFS_UNLOCK = 9'h18D;
    localparam logic [ADDR_W-1:0] OFS_DATA = 9'h10C;
    localparam logic [ADDR_W-1:0] OFS_ADDR = 9'h10D;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 9'h00D;
    localparam logic [ADDR_W-1:0] OFS_IMASK = 9'h08D;

    // ********************************************************
    // control register fields
    // ********************************************************
    localparam int BIT_RD = 0;
    localparam int BIT_WR = 1;
    localparam int BIT_WRITE_ENABLE_BIT = 2;
    localparam int BIT_ERR = 3;
    localparam int BIT_SEL = 7;

    // ********************************************************
    // interrupt status fields, unlock keys, reset values
    // ********************************************************
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam logic [DATA_W-1:0] KEY_FIRST = 8'h55;
    localparam logic [DATA_W-1:0] KEY_SECOND = 8'hAA;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_ZERO = 2'h0;

    // ********************************************************
    // timing and size
    // ********************************************************
    localparam int CLK_KHZ = 20000;
    localparam int WR_TIME_US = 4000;
    localparam int WR_CYCLES = WR_TIME_US * CLK_KHZ / 1000;
    localparam int MEM_DEPTH = 256;

    // unlock sequence tracker
    typedef enum logic [2:0] {
        UNL_IDLE = 3'b001,
        UNL_GOT1 = 3'b010,
        UNL_ARMED = 3'b100
    } eac_unlock_e;

endpackage

// ==== design/eac_timer.sv ====
// eac_timer: countdown that times one eeprom write cycle
// assumes start and abort come from logic on core_clk
`timescale 1ns/1ps
module eac_timer #(
    parameter int unsigned CYCLES = 80000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic abort,
    // status
    output logic busy,
    output logic done
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_ZERO = CW'(0);

    // refused at elaboration: a shorter count lets done meet the start
    if (CYCLES < 2) begin : g_bad_cycles
        $error("eac_timer: CYCLES must be at least 2");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    // ********************************************************
    // countdown
    // ********************************************************
    // done only fires when the count runs out, never on abort
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (abort) begin
            cnt_nxt = CNT_ZERO;
        end else if (start) begin
            cnt_nxt = CW'(CYCLES);
        end else if (cnt_r != CNT_ZERO) begin
            cnt_nxt = cnt_r - CNT_ONE;
            done_nxt = (cnt_r == CNT_ONE);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= CNT_ZERO;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = (cnt_r != CNT_ZERO);
    assign done = done_r;

endmodule // eac_timer

// ==== design/eac_top.sv ====
// eac_top: data eeprom access control with byte array and interrupt
// assumes a one-cycle register port on core_clk and reset requests
// from the reset controller already on core_clk
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module eac_top
    import eac_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = eac_pkg::WR_CYCLES,
    parameter int unsigned DEPTH = eac_pkg::MEM_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // warm reset requests
    input wire logic masterClearReset,
    input wire logic watchdogTimeout,
    // register port
    input wire logic [eac_pkg::ADDR_W-1:0] busAddr,
    input wire logic [eac_pkg::DATA_W-1:0] busWdata,
    input wire logic busWrite,
    input wire logic busRead,
    output logic [eac_pkg::DATA_W-1:0] busRdata,
    // interrupt
    output logic irq
);
    import eac_pkg::*;

    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // refused at elaboration: the index is cut to IW bits
    if (DEPTH < 2 || DEPTH > 256 ||
            (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("eac_top: DEPTH must be a power of two, 2..256");
    end

    // ********************************************************
    // state
    // ********************************************************
    logic sel_r, sel_nxt;
    logic err_r, err_nxt;
    logic write_enable_bit_r, write_enable_bit_nxt;
    logic wr_r, wr_nxt;
    logic rd_r, rd_nxt;
    eac_unlock_e unl_r, unl_nxt;
    logic [DATA_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic [DATA_W-1:0] wAddr_r, wAddr_nxt;
    logic [DATA_W-1:0] wData_r, wData_nxt;
    logic [IRQ_W-1:0] istat_r, istat_nxt;
    logic [IRQ_W-1:0] imask_r, imask_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic [DATA_W-1:0] mem_r [DEPTH];

    logic warmRst;
    logic startWr;
    logic tmrBusy;
    logic tmrDone;
    logic [DATA_W-1:0] memRd;
    logic [DATA_W-1:0] ctrlView;
    logic [IRQ_W-1:0] irqEv;
    logic [IRQ_W-1:0] irqClr;

    // ********************************************************
    // write cycle timer
    // ********************************************************
    eac_timer #(
        .CYCLES(WRITE_CYCLES)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(startWr),
        .abort(warmRst),
        .busy(tmrBusy),
        .done(tmrDone)
    );

    // ********************************************************
    // array read and control view
    // ********************************************************
    // addresses past the implemented size read as zero
    always_comb begin
        warmRst = masterClearReset | watchdogTimeout;
        if (addr_r < DEPTH) begin
            memRd = mem_r[addr_r[IW-1:0]];
        end else begin
            memRd = BYTE_ZERO;
        end
        ctrlView = BYTE_ZERO;
        ctrlView[BIT_SEL] = sel_r;
        ctrlView[BIT_ERR] = err_r;
        ctrlView[BIT_WRITE_ENABLE_BIT] = write_enable_bit_r;
        ctrlView[BIT_WR] = wr_r;
        ctrlView[BIT_RD] = rd_r;
    end

    // ********************************************************
    // control, unlock and holding registers
    // ********************************************************
    // a warm reset wins over any bus write in the same cycle
    always_comb begin
        sel_nxt = sel_r;
        err_nxt = err_r;
        write_enable_bit_nxt = write_enable_bit_r;
        wr_nxt = wr_r;
        rd_nxt = 1'b0;
        unl_nxt = unl_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        wAddr_nxt = wAddr_r;
        wData_nxt = wData_r;
        imask_nxt = imask_r;
        irqClr = IRQ_ZERO;
        irqEv = IRQ_ZERO;
        startWr = 1'b0;
        if (tmrDone) begin
            wr_nxt = 1'b0;
            irqEv[IRQ_DONE] = 1'b1;
        end
        if (warmRst) begin
            // address and data survive so software can retry
            if (wr_r) begin
                err_nxt = 1'b1;
                irqEv[IRQ_ERR] = 1'b1;
            end
            wr_nxt = 1'b0;
            sel_nxt = 1'b0;
            unl_nxt = UNL_IDLE;
        end else if (busWrite) begin
            // any write between the keys breaks the sequence
            unl_nxt = UNL_IDLE;
            unique case (busAddr)
                OFS_CTRL: begin
                    sel_nxt = busWdata[BIT_SEL];
                    err_nxt = busWdata[BIT_ERR];
                    write_enable_bit_nxt = busWdata[BIT_WRITE_ENABLE_BIT];
                    // zeros to the start bits change nothing
                    if (busWdata[BIT_RD] && !busWdata[BIT_SEL]) begin
                        rd_nxt = 1'b1;
                        data_nxt = memRd;
                    end
                    // program memory side is not served here
                    if (busWdata[BIT_WR] && !wr_r && write_enable_bit_r &&
                            unl_r == UNL_ARMED &&
                            !busWdata[BIT_SEL]) begin
                        startWr = 1'b1;
                    end
                end
                OFS_UNLOCK: begin
                    // no storage, only the sequence tracker moves
                    if (busWdata == KEY_FIRST) begin
                        unl_nxt = UNL_GOT1;
                    end else if (busWdata == KEY_SECOND &&
                            unl_r == UNL_GOT1) begin
                        unl_nxt = UNL_ARMED;
                    end
                end
                OFS_ADDR: begin
                    addr_nxt = busWdata;
                end
                OFS_DATA: begin
                    data_nxt = busWdata;
                end
                OFS_ISTAT: begin
                    irqClr = busWdata[IRQ_W-1:0];
                end
                OFS_IMASK: begin
                    imask_nxt = busWdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // latch the target so later register writes leave it alone
        if (startWr) begin
            wr_nxt = 1'b1;
            wAddr_nxt = addr_r;
            wData_nxt = data_r;
        end
        // a new event beats a clear in the same cycle
        istat_nxt = (istat_r & ~irqClr) | irqEv;
        irq_nxt = |(istat_r & imask_r);
    end

    // ********************************************************
    // read port
    // ********************************************************
    // data stands for one cycle only, zero otherwise
    always_comb begin
        rdata_nxt = BYTE_ZERO;
        if (busRead) begin
            unique case (busAddr)
                OFS_CTRL: rdata_nxt = ctrlView;
                OFS_UNLOCK: rdata_nxt = BYTE_ZERO;
                OFS_ADDR: rdata_nxt = addr_r;
                OFS_DATA: rdata_nxt = data_r;
                OFS_ISTAT: rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, istat_r};
                OFS_IMASK: rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, imask_r};
                default: rdata_nxt = BYTE_ZERO;
            endcase
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_r <= 1'b0;
            err_r <= 1'b0;
            write_enable_bit_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            unl_r <= UNL_IDLE;
            addr_r <= BYTE_ZERO;
            data_r <= BYTE_ZERO;
            wAddr_r <= BYTE_ZERO;
            wData_r <= BYTE_ZERO;
            istat_r <= IRQ_ZERO;
            imask_r <= IRQ_ZERO;
            rdata_r <= BYTE_ZERO;
            irq_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            err_r <= err_nxt;
            write_enable_bit_r <= write_enable_bit_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            unl_r <= unl_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            wAddr_r <= wAddr_nxt;
            wData_r <= wData_nxt;
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // array cells change only when the timer expires
    always_ff @(posedge core_clk) begin
        if (tmrDone && wAddr_r < DEPTH) begin
            mem_r[wAddr_r[IW-1:0]] <= wData_r;
        end
    end

    assign busRdata = rdata_r;
    assign irq = irq_r;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_wr_done;
        tmrDone && !startWr |=> !wr_r && istat_r[IRQ_DONE];
    endproperty
    a_wr_done: assert property (p_wr_done)
        else $error("write bit or done flag wrong at completion");

    property p_rd_pulse;
        rd_r |=> !rd_r;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read bit did not self clear");

    property p_no_abort;
        wr_r && !tmrDone && !warmRst |=> wr_r;
    endproperty
    a_no_abort: assert property (p_no_abort)
        else $error("write bit dropped before completion");

    property p_read_data;
        busWrite && busAddr == OFS_CTRL && busWdata[BIT_RD] &&
            !busWdata[BIT_SEL] && !warmRst |=> data_r == $past(memRd);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("holding register not loaded by read");

    property p_hold;
        !busWrite |=> $stable(data_r) && $stable(addr_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("holding register changed without cause");

    property p_unlock;
        $rose(wr_r) |-> $past(unl_r) == UNL_ARMED && $past(write_enable_bit_r);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("write started without unlock and enable");

    property p_write_enable_bit_hw;
        !(busWrite && busAddr == OFS_CTRL) |=> $stable(write_enable_bit_r);
    endproperty
    a_write_enable_bit_hw: assert property (p_write_enable_bit_hw)
        else $error("write enable changed by hardware");

    property p_write_enable_bit_off;
        wr_r && busWrite && busAddr == OFS_CTRL &&
            !busWdata[BIT_WRITE_ENABLE_BIT] && !tmrDone && !warmRst |=> wr_r;
    endproperty
    a_write_enable_bit_off: assert property (p_write_enable_bit_off)
        else $error("clearing enable disturbed a write");

    property p_abort_err;
        warmRst && wr_r |=> err_r && !wr_r && $stable(addr_r) &&
            $stable(data_r);
    endproperty
    a_abort_err: assert property (p_abort_err)
        else $error("interrupted write not flagged");

    property p_unl_zero;
        busRead && busAddr == OFS_UNLOCK |=> busRdata == BYTE_ZERO;
    endproperty
    a_unl_zero: assert property (p_unl_zero)
        else $error("unlock register read not zero");

    property p_timed;
        $rose(wr_r) |-> !tmrDone [*2] ##1 tmrBusy;
    endproperty
    a_timed: assert property (p_timed)
        else $error("write finished before the countdown");

endmodule // eac_top

// ==== verif/tb.sv ====
// tb: self-checking bench for the eeprom access control block
// assumes eac_pkg compiled first; eac_top holds its own assertions
`timescale 1ns/1ps
module tb;
    import eac_pkg::*;

    // ************************************************************
    // clock, reset and design ports
    // ************************************************************
    localparam int WCYC = 16;
    logic core_clk;
    logic rst;
    logic masterClearReset;
    logic watchdogTimeout;
    logic [ADDR_W-1:0] busAddr;
    logic [DATA_W-1:0] busWdata;
    logic busWrite;
    logic busRead;
    logic [DATA_W-1:0] busRdata;
    logic irq;
    int nFail;
    int checksDone;
    int cycles;
    logic [DATA_W-1:0] got;

    // short write count keeps the run brief
    eac_top #(.WRITE_CYCLES(WCYC), .DEPTH(MEM_DEPTH)) eac_top_i (
        .core_clk(core_clk),
        .rst(rst),
        .masterClearReset(masterClearReset),
        .watchdogTimeout(watchdogTimeout),
        .busAddr(busAddr),
        .busWdata(busWdata),
        .busWrite(busWrite),
        .busRead(busRead),
        .busRdata(busRdata),
        .irq(irq)
    );

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ************************************************************
    // bus tasks and comparison
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busWrite <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge core_clk);
        busWrite <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        busRead <= 1'b1;
        busAddr <= a;
        @(posedge core_clk);
        busRead <= 1'b0;
        #1;
        d = busRdata;
    endtask

    task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
                         input logic [7:0] msk, input string what);
        logic [7:0] v;
        rd(a, v);
        check(v & msk, exp, what);
    endtask

    // no handler runs in the bench, so nothing breaks into the keys
    task automatic startWrite(input logic [7:0] a, input logic [7:0] d);
        wr(OFS_ADDR, a);
        wr(OFS_DATA, d);
        wr(OFS_CTRL, 8'h04);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_CTRL, 8'h06);
    endtask

    // bounded poll so a stuck write bit cannot hang the run
    task automatic waitDone;
        logic [7:0] v;
        int i;
        v = 8'h02;
        for (i = 0; i < 30 && v[BIT_WR] !== 1'b0; i++) begin
            rd(OFS_CTRL, v);
        end
        check(v & 8'h02, 8'h00, "write bit never cleared");
    endtask

    task automatic endTest(input string name);
        $display("test %s finished, mismatches so far %0d", name, nFail);
    endtask

    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ************************************************************
    // hang guard
    // ************************************************************
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            nFail++;
            $display("wrong value at %0t: run did not end", $time);
            completeRun();
        end
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        masterClearReset = 1'b0;
        watchdogTimeout = 1'b0;
        busAddr = 9'h000;
        busWdata = 8'h00;
        busWrite = 1'b0;
        busRead = 1'b0;
        nFail = 0;
        checksDone = 0;
        cycles = 0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;

        // reset state, unlock port and an unmapped address
        rdChk(OFS_CTRL, 8'h00, 8'h87, "control after reset");
        wr(OFS_UNLOCK, KEY_FIRST);
        rdChk(OFS_UNLOCK, 8'h00, 8'hFF, "unlock port");
        rdChk(9'h1FF, 8'h00, 8'hFF, "unmapped read");
        check({7'h00, irq}, 8'h00, "irq after reset");
        endTest("reset");

        // start refused without enable, then broken unlock sequences and a program-side start
        wr(OFS_CTRL, 8'h00);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_CTRL, 8'h02);
        rdChk(OFS_CTRL, 8'h00, 8'h8F, "start without enable");
        for (int k = 0; k < 5; k++) begin
            wr(OFS_CTRL, 8'h04);
            if (k != 1) wr(OFS_UNLOCK, KEY_FIRST);
            if (k == 2) wr(OFS_ADDR, 8'h10);
            if (k == 3) wr(OFS_UNLOCK, 8'h56);
            if (k != 0) wr(OFS_UNLOCK, KEY_SECOND);
            if (k == 1) wr(OFS_UNLOCK, KEY_FIRST);
            wr(OFS_CTRL, (k == 4) ? 8'h86 : 8'h06);
            got = (k == 4) ? 8'h84 : 8'h04;
            rdChk(OFS_CTRL, got, 8'h8F, "bad sequence");
        end
        endTest("refused starts");

        // full write with timing, flag, interrupt and clear
        wr(OFS_CTRL, 8'h00);
        wr(OFS_IMASK, 8'h01);
        startWrite(8'h10, 8'h5A);
        rdChk(OFS_CTRL, 8'h06, 8'h8F, "write started");
        // next-to-last busy cycle, then the first cleared one, two cycles apart
        repeat (WCYC - 4) @(posedge core_clk);
        rdChk(OFS_CTRL, 8'h06, 8'h8F, "write still busy");
        rdChk(OFS_CTRL, 8'h04, 8'h8F, "write ended");
        rdChk(OFS_ISTAT, 8'h01, 8'hFF, "done flag");
        check({7'h00, irq}, 8'h01, "irq on done");
        wr(OFS_ISTAT, 8'h01);
        rdChk(OFS_ISTAT, 8'h00, 8'hFF, "done flag cleared");
        check({7'h00, irq}, 8'h00, "irq after clear");
        endTest("write");

        // read back, self-clearing read bit, holding register
        wr(OFS_DATA, 8'h00);
        wr(OFS_CTRL, 8'h01);
        rdChk(OFS_DATA, 8'h5A, 8'hFF, "read back");
        rdChk(OFS_CTRL, 8'h00, 8'h8F, "read bit cleared");
        wr(OFS_ADDR, 8'h20);
        rdChk(OFS_DATA, 8'h5A, 8'hFF, "holding kept");
        wr(OFS_DATA, 8'h33);
        rdChk(OFS_DATA, 8'h33, 8'hFF, "holding replaced");
        wr(OFS_CTRL, 8'h81);
        rdChk(OFS_DATA, 8'h33, 8'hFF, "program read ignored");
        wr(OFS_CTRL, 8'h00);
        endTest("read");

        // enable dropped mid-write, masked completion
        wr(OFS_IMASK, 8'h00);
        startWrite(8'h20, 8'hC3);
        wr(OFS_CTRL, 8'h00);
        rdChk(OFS_CTRL, 8'h02, 8'h8F, "zero write ignored");
        waitDone();
        rdChk(OFS_ISTAT, 8'h01, 8'hFF, "done despite drop");
        check({7'h00, irq}, 8'h00, "irq masked");
        wr(OFS_IMASK, 8'h01);
        repeat (2) @(posedge core_clk);
        check({7'h00, irq}, 8'h01, "irq unmasked");
        wr(OFS_ISTAT, 8'h01);
        wr(OFS_CTRL, 8'h01);
        rdChk(OFS_DATA, 8'hC3, 8'hFF, "byte written");
        endTest("enable drop");

        // warm reset in mid-write, both sources
        wr(OFS_IMASK, 8'h02);
        for (int k = 0; k < 2; k++) begin
            startWrite(8'h10, 8'h9A);
            repeat (3) @(posedge core_clk);
            if (k == 0) masterClearReset <= 1'b1;
            else watchdogTimeout <= 1'b1;
            @(posedge core_clk);
            masterClearReset <= 1'b0;
            watchdogTimeout <= 1'b0;
            rdChk(OFS_CTRL, 8'h0C, 8'h8F, "error after abort");
            rdChk(OFS_ISTAT, 8'h02, 8'hFF, "error flag");
            check({7'h00, irq}, 8'h01, "irq on error");
            rdChk(OFS_ADDR, 8'h10, 8'hFF, "address kept");
            rdChk(OFS_DATA, 8'h9A, 8'hFF, "data kept");
            wr(OFS_ISTAT, 8'h02);
            wr(OFS_CTRL, 8'h01);
            rdChk(OFS_DATA, 8'h5A, 8'hFF, "byte untouched");
        end
        endTest("warm reset");
        completeRun();
    end
endmodule // tb
